/* File: src/sadc_pkg.sv */
// Functional notes
// - drive end-of-conversion low at tenth falling clock, high when result ready
// - take four address bits on first four rising clocks, select after fourth
// - sample from fourth falling clock, hold the sample at the tenth
// - after the MSB, shift nine more bits out on falling clocks, MSB first
// - start conversion at tenth falling clock, never earlier
// - while select is high, ignore address and clock, data output released
// - select falling starts a sequence and drives the data output
// - MSB appears at select fall, end-of-conversion rise, or after sixteenth fall
// - at tenth falling clock force the data output low, padding with zeros
// - six transfer modes from select behaviour and clock count
// - ten-clock transfers are always fast: transfer ends before conversion
// - select falling resets counters and control within three system clocks
// - codes 0 to 10 external, 11 to 13 self-test, fourteen inputs in all
package sadc_pkg;

   localparam int        CNT_W        = 5;       // width of link edge counters
   localparam int        RES_BITS     = 10;      // result width
   localparam logic [2:0] ADDR_BITS   = 3'h4;    // address bits per transfer
   localparam logic [4:0] SAMPLE_FALL = 5'h04;   // falling edge that opens sampling
   localparam logic [4:0] HOLD_FALL   = 5'h0a;   // falling edge that holds and converts
   localparam logic [4:0] LONG_FALL   = 5'h10;   // last falling edge of a long transfer
   localparam logic [4:0] SLOW_RISE   = 5'h0b;   // rising edge that marks a slow transfer
   localparam logic [3:0] MAX_CHAN    = 4'hd;    // highest selectable input code

   typedef enum logic {CV_IDLE, CV_WAIT} sadc_cv_state_t;

   // binary to gray for pointer crossings
   function automatic logic [CNT_W-1:0] sadc_bin2gray(input logic [CNT_W-1:0] b);
      return b ^ (b >> 1);
   endfunction

   // gray back to binary
   function automatic logic [CNT_W-1:0] sadc_gray2bin(input logic [CNT_W-1:0] g);
      logic [CNT_W-1:0] b;
      b = '0;
      for (int i = CNT_W - 1; i >= 0; i--) begin
         b[i] = g[i] ^ ((i == CNT_W - 1) ? 1'b0 : b[i+1]);
      end
      return b;
   endfunction

endpackage

/* File: src/sadc_conv_if.sv */
`timescale 1ns/1ps
// handover between sequencer and conversion controller
interface sadc_conv_if #(parameter int DATA_W = 10);
   logic              start;
   logic [DATA_W-1:0] result;
   logic              done;

   modport ctrl (output start, input result, input done);
   modport conv (input start, output result, output done);
endinterface

/* File: src/sadc_bitmem.sv */
`timescale 1ns/1ps
// address bit store: written on the link clock, read on the system clock
module sadc_bitmem #(
   parameter int AW = 5
) (
   // write side, link domain
   input  wire logic          wr_clk,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic          wr_data,
   // read side, system domain
   input  wire logic          ref_clk,
   input  wire logic          rd_en,
   input  wire logic [AW-1:0] rd_addr,
   output logic               rd_data
);
   logic [2**AW-1:0] mem_reg;

   // reader only looks at slots whose gray pointer has already crossed
   always_ff @(posedge wr_clk) begin
      if (wr_en) begin
         mem_reg[wr_addr] <= wr_data;
      end
   end

   // registered read port
   always_ff @(posedge ref_clk) begin
      if (rd_en) begin
         rd_data <= mem_reg[rd_addr];
      end
   end
endmodule

/* File: src/sadc_conv.sv */
`timescale 1ns/1ps
// internal conversion controller: runs the array and returns the result
module sadc_conv import sadc_pkg::*; #(
   parameter int DATA_W = RES_BITS
) (
   // system
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // sequencer side
   sadc_conv_if.conv              cif,
   // converter array
   output logic                   sar_start,
   input  wire logic [DATA_W-1:0] sar_result,
   input  wire logic              sar_ready
);
   typedef struct packed {
      sadc_cv_state_t    state;
      logic              start;
      logic              done;
      logic [DATA_W-1:0] result;
   } sadc_cv_t;

   sadc_cv_t cv_reg, cv_next;

   // a new start restarts the array; the older request is dropped
   always_comb begin
      cv_next       = cv_reg;
      cv_next.start = 1'b0;
      cv_next.done  = 1'b0;
      if (cif.start) begin
         cv_next.start = 1'b1;
         cv_next.state = CV_WAIT;
      end else begin
         unique case (cv_reg.state)
            CV_IDLE: ;
            CV_WAIT: begin
               if (sar_ready) begin
                  cv_next.result = sar_result;
                  cv_next.done   = 1'b1;
                  cv_next.state  = CV_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cv_reg <= '{state: CV_IDLE, start: 1'b0, done: 1'b0, result: '0};
      end else begin
         cv_reg <= cv_next;
      end
   end

   assign sar_start  = cv_reg.start;
   assign cif.done   = cv_reg.done;
   assign cif.result = cv_reg.result;

   chk_done_follows_ready: assert property (@(posedge ref_clk) disable iff (rst)
      (cv_reg.state == CV_WAIT && sar_ready && !cif.start) |=> (cif.done && cif.result == $past(sar_result)))
      else $error("result ready but no done pulse");
endmodule

/* File: src/sadc_ctrl.sv */
`timescale 1ns/1ps
// serial interface and sequencer of the converter
module sadc_ctrl import sadc_pkg::*; #(
   parameter int DATA_W = RES_BITS
) (
   // system
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // serial link pins
   input  wire logic              serial_shift_clock,
   input  wire logic              device_select_n,
   input  wire logic              channel_address_in,
   output logic                   result_serial_out,
   output logic                   result_serial_oe,
   output logic                   conversion_done,
   // analog front end
   output logic [3:0]             mux_sel,
   output logic                   mux_valid,
   output logic                   sample_en,
   output logic                   sar_start,
   input  wire logic [DATA_W-1:0] sar_result,
   input  wire logic              sar_ready
);

   // the sequencing is built around the tenth falling edge
   if (DATA_W != int'(HOLD_FALL)) begin : g_bad_width
      $error("sadc_ctrl: DATA_W must equal the hold edge count");
   end

   ////////////////////////////////////////////////////////////////////////////
   // link domain: edge counters and address capture on the shift clock

   typedef struct packed {
      logic             rst_meta;
      logic             rst_sync;
      logic [CNT_W-1:0] gray;
   } sadc_lrise_t;

   typedef struct packed {
      logic [CNT_W-1:0] gray;
   } sadc_lfall_t;

   sadc_lrise_t lr_reg, lr_next;
   sadc_lfall_t lf_reg, lf_next;

   // counters are never cleared per frame; the system side keeps a base
   always_comb begin
      lr_next          = lr_reg;
      lr_next.rst_meta = rst;
      lr_next.rst_sync = lr_reg.rst_meta;
      lr_next.gray     = lr_reg.rst_sync ? '0
                         : sadc_bin2gray(CNT_W'(sadc_gray2bin(lr_reg.gray) + 1'b1));
   end

   always_ff @(posedge serial_shift_clock) begin
      lr_reg <= lr_next;
   end

   // falling edges counted on the opposite clock edge
   always_comb begin
      lf_next      = lf_reg;
      lf_next.gray = lr_reg.rst_sync ? '0
                     : sadc_bin2gray(CNT_W'(sadc_gray2bin(lf_reg.gray) + 1'b1));
   end

   always_ff @(negedge serial_shift_clock) begin
      lf_reg <= lf_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // system domain state

   typedef struct packed {
      logic              cs_meta;
      logic              cs_sync;
      logic              cs_prev;
      logic [CNT_W-1:0]  rg_meta;
      logic [CNT_W-1:0]  rg_sync;
      logic [CNT_W-1:0]  fg_meta;
      logic [CNT_W-1:0]  fg_sync;
      logic              active;
      logic [CNT_W-1:0]  rise_base;
      logic [CNT_W-1:0]  fall_base;
      logic [2:0]        addr_cnt;
      logic              rd_pend;
      logic [3:0]        addr_sr;
      logic [3:0]        mux_sel;
      logic              mux_valid;
      logic              ten_seen;
      logic              wait16;
      logic              sample;
      logic              start;
      logic              eoc;
      logic [DATA_W-1:0] result;
      logic              dout;
      logic              oe;
   } sadc_st_t;

   sadc_st_t st_reg, st_next;

   sadc_conv_if #(.DATA_W(DATA_W)) cif ();

   logic [CNT_W-1:0] rise_now;
   logic [CNT_W-1:0] fall_now;
   logic [CNT_W-1:0] rise_rel;
   logic [CNT_W-1:0] fall_rel;
   logic             cs_fall;
   logic             hit;
   logic             restart;
   logic             rd_go;
   logic [CNT_W-1:0] rd_addr;
   logic             mem_rdata;
   logic             exp_bit;

   // address bits land in a slot indexed by the rising edge count
   sadc_bitmem #(.AW(CNT_W)) u_bitmem (
      .wr_clk  (serial_shift_clock),
      .wr_en   (!lr_reg.rst_sync),
      .wr_addr (sadc_gray2bin(lr_reg.gray)),
      .wr_data (channel_address_in),
      .ref_clk (ref_clk),
      .rd_en   (rd_go),
      .rd_addr (rd_addr),
      .rd_data (mem_rdata)
   );

   sadc_conv #(.DATA_W(DATA_W)) u_conv (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .cif        (cif.conv),
      .sar_start  (sar_start),
      .sar_result (sar_result),
      .sar_ready  (sar_ready)
   );

   // frame-relative edge counts, events and the bit due on the pin
   always_comb begin
      rise_now = sadc_gray2bin(st_reg.rg_sync);
      fall_now = sadc_gray2bin(st_reg.fg_sync);
      rise_rel = CNT_W'(rise_now - st_reg.rise_base);
      fall_rel = CNT_W'(fall_now - st_reg.fall_base);
      cs_fall  = st_reg.cs_prev && !st_reg.cs_sync;
      // >= because a fast shift clock may move two edges per sample
      hit      = st_reg.active && !st_reg.ten_seen && !st_reg.cs_sync
                 && fall_rel >= HOLD_FALL;
      // continuous-select modes begin again at done or after edge sixteen
      restart  = !st_reg.cs_sync && st_reg.active && !cs_fall
                 && ((cif.done && st_reg.ten_seen
                      && (fall_rel >= LONG_FALL || rise_rel < SLOW_RISE))
                     || (st_reg.wait16 && fall_rel >= LONG_FALL));
      rd_go    = !st_reg.cs_sync && st_reg.active && !cs_fall && !restart
                 && !st_reg.rd_pend && st_reg.addr_cnt < ADDR_BITS
                 && rise_rel > CNT_W'(st_reg.addr_cnt);
      rd_addr  = CNT_W'(st_reg.rise_base + CNT_W'(st_reg.addr_cnt));
      exp_bit  = 1'b0;
      if (fall_rel < CNT_W'(DATA_W)) begin
         exp_bit = st_reg.result[DATA_W - 1 - int'(fall_rel)];
      end
   end

   // sequencer next state
   always_comb begin
      st_next         = st_reg;
      st_next.cs_meta = device_select_n;
      st_next.cs_sync = st_reg.cs_meta;
      st_next.cs_prev = st_reg.cs_sync;
      st_next.rg_meta = lr_reg.gray;
      st_next.rg_sync = st_reg.rg_meta;
      st_next.fg_meta = lf_reg.gray;
      st_next.fg_sync = st_reg.fg_meta;
      st_next.start   = 1'b0;

      // a finished conversion replaces the result and raises the flag
      if (cif.done) begin
         st_next.result = cif.result;
         st_next.eoc    = 1'b1;
      end

      if (st_reg.cs_sync) begin
         // deselected: clock and address ignored, output released
         st_next.active    = 1'b0;
         st_next.oe        = 1'b0;
         st_next.dout      = 1'b0;
         st_next.sample    = 1'b0;
         st_next.wait16    = 1'b0;
         st_next.rise_base = rise_now;
         st_next.fall_base = fall_now;
      end else if (cs_fall || restart) begin
         // new frame: counters cleared, MSB of the latest result shown
         st_next.active    = 1'b1;
         st_next.oe        = 1'b1;
         st_next.rise_base = rise_now;
         st_next.fall_base = fall_now;
         st_next.addr_cnt  = 3'h0;
         st_next.rd_pend   = 1'b0;
         st_next.ten_seen  = 1'b0;
         st_next.wait16    = 1'b0;
         st_next.sample    = 1'b0;
         st_next.dout      = st_next.result[DATA_W-1];
      end else if (st_reg.active) begin
         // address bits, one read per captured rising edge
         if (st_reg.rd_pend) begin
            st_next.rd_pend  = 1'b0;
            st_next.addr_sr  = {st_reg.addr_sr[2:0], mem_rdata};
            st_next.addr_cnt = st_reg.addr_cnt + 3'h1;
            if (st_reg.addr_cnt == ADDR_BITS - 3'h1) begin
               st_next.mux_sel   = {st_reg.addr_sr[2:0], mem_rdata};
               st_next.mux_valid = {st_reg.addr_sr[2:0], mem_rdata}
                                   <= MAX_CHAN;
            end
         end else if (rd_go) begin
            st_next.rd_pend = 1'b1;
         end

         // sampling window between the fourth and the tenth falling edge
         st_next.sample = !st_reg.ten_seen && fall_rel >= SAMPLE_FALL
                          && fall_rel < HOLD_FALL;

         // result bits then zero padding from the tenth edge on
         st_next.dout = exp_bit;

         if (hit) begin
            st_next.ten_seen = 1'b1;
            st_next.sample   = 1'b0;
            st_next.start    = 1'b1;
            st_next.eoc      = 1'b0;
         end

         // slow transfer: conversion ended before the clocks did
         if (cif.done && st_reg.ten_seen) begin
            st_next.wait16 = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_reg <= '{cs_meta: 1'b1, cs_sync: 1'b1, cs_prev: 1'b1,
                     rg_meta: '0, rg_sync: '0, fg_meta: '0, fg_sync: '0,
                     active: 1'b0, rise_base: '0, fall_base: '0,
                     addr_cnt: 3'h0, rd_pend: 1'b0, addr_sr: 4'h0,
                     mux_sel: 4'h0, mux_valid: 1'b0, ten_seen: 1'b0,
                     wait16: 1'b0, sample: 1'b0, start: 1'b0, eoc: 1'b1,
                     result: '0, dout: 1'b0, oe: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   // pins and front end straight from flops
   assign cif.start         = st_reg.start;
   assign result_serial_out = st_reg.dout;
   assign result_serial_oe  = st_reg.oe;
   assign conversion_done   = st_reg.eoc;
   assign mux_sel           = st_reg.mux_sel;
   assign mux_valid         = st_reg.mux_valid;
   assign sample_en         = st_reg.sample;

   ////////////////////////////////////////////////////////////////////////////
   // checks on the system domain

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_frame_begin;
      !st_reg.cs_sync && (cs_fall || restart);
   endsequence

   sequence s_tenth_edge;
      hit;
   endsequence

   sequence s_shift_step;
      st_reg.active && !st_reg.cs_sync && !cs_fall && !restart && !hit
      && fall_rel >= 5'h01 && fall_rel < HOLD_FALL;
   endsequence

   chk_eoc_fall_tenth: assert property (s_tenth_edge |=> !conversion_done)
      else $error("done flag not low after tenth edge");

   chk_eoc_held_low: assert property (
      (!conversion_done && !cif.done) |=> !conversion_done)
      else $error("done flag rose without a result");

   // a tenth edge in the same cycle starts a fresh conversion, so low wins there
   chk_eoc_rise_done: assert property ((cif.done && !hit) |=> conversion_done)
      else $error("done flag not raised after result");

   chk_mux_after_four: assert property (
      $changed(mux_sel) |-> $past(st_reg.addr_cnt) == ADDR_BITS - 3'h1)
      else $error("channel changed before four address bits");

   chk_sample_window: assert property (
      sample_en |-> $past(fall_rel) >= SAMPLE_FALL && $past(fall_rel) < HOLD_FALL)
      else $error("sampling outside its window");

   chk_shift_order: assert property (
      s_shift_step |=> result_serial_out == $past(exp_bit))
      else $error("result bit out of order");

   chk_start_tenth: assert property (
      cif.start |-> $past(hit) && $past(fall_rel) >= HOLD_FALL)
      else $error("conversion started before tenth edge");

   chk_hiz_idle: assert property (
      st_reg.cs_sync |=> !result_serial_oe ##1 (!result_serial_oe || !st_reg.cs_prev))
      else $error("output driven while deselected");

   chk_frame_msb: assert property (
      s_frame_begin |=> result_serial_oe && result_serial_out == st_reg.result[DATA_W-1])
      else $error("msb not presented at frame start");

   chk_zero_pad: assert property (
      (st_reg.active && !st_reg.cs_sync && !cs_fall && !restart && fall_rel >= HOLD_FALL)
      |=> !result_serial_out)
      else $error("nonzero bit after tenth edge");

   chk_cs_reset: assert property (
      (st_reg.cs_prev && !st_reg.cs_sync) |=> st_reg.addr_cnt == 3'h0 && !st_reg.ten_seen
      && result_serial_oe)
      else $error("select fall did not clear the sequence");
endmodule

/* File: tb/sadc_host.sv */
`timescale 1ns/1ps
// host serial port: frames the link, shifts the address, collects the result
module sadc_host (
   // link clock source, free running
   input  wire logic lnk_clk,
   // link pins
   output logic      serial_shift_clock,
   output logic      device_select_n,
   output logic      channel_address_in,
   input  wire logic result_serial_out,
   input  wire logic result_serial_oe
);
   int   rise_cnt;
   int   hp;
   logic last_drv;
   logic pin;

   ////////////////////////////////////////////////////////////////////////////////
   // released pin has no pull, so show the inverse of the last driven level
   always @(posedge lnk_clk) begin
      if (result_serial_oe === 1'b1) last_drv <= result_serial_out;
   end
   assign pin = (result_serial_oe === 1'b1) ? result_serial_out : ~last_drv;

   // shift clock idles low; it runs inside frames and, with select high, in idle_clocks
   initial begin
      serial_shift_clock = 1'b0;
      device_select_n    = 1'b1;
      channel_address_in = 1'b0;
      rise_cnt           = 0;
      hp                 = 10;
      last_drv           = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // half period in link clocks; 10 keeps well clear of edge merging
   task automatic half();
      repeat (hp) @(posedge lnk_clk);
      #1;
   endtask

   // clocks with select high: ignored by the device, needed during reset
   task automatic idle_clocks(input int n);
      channel_address_in = 1'b1;
      for (int i = 0; i < n; i++) begin
         half();
         serial_shift_clock = 1'b1;
         half();
         serial_shift_clock = 1'b0;
      end
   endtask

   // one transfer of n clocks, address msb first, result taken on rising edges
   task automatic xfer(input logic [3:0] addr, input int n, input logic keep,
                       output logic [15:0] got);
      got      = '0;
      rise_cnt = 0;
      if (device_select_n === 1'b1) begin
         device_select_n = 1'b0;
         repeat (20) @(posedge lnk_clk);
         #1;
      end
      for (int i = 0; i < n; i++) begin
         channel_address_in = (i < 4) ? addr[3-i] : 1'b0;
         half();
         rise_cnt           = i + 1;
         got                = {got[14:0], pin};
         serial_shift_clock = 1'b1;
         half();
         serial_shift_clock = 1'b0;
      end
      half();
      if (!keep) device_select_n = 1'b1;
   endtask

   // end a continuous-select run
   task automatic release_sel();
      device_select_n = 1'b1;
      half();
   endtask
endmodule

/* File: tb/serial_adc_control_interface_bench.sv */
`timescale 1ns/1ps
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin failures++; \
   $display("[FAIL] %0t %s", $time, m); end end
module serial_adc_control_interface_bench import sadc_pkg::*;;
   typedef struct {logic [3:0] addr; int n; logic keep; logic slow; logic [9:0] val;} sadc_row_t;
   logic        ref_clk, rst, lnk_clk, sck, sel_n, adr, dout, doe, done;
   logic [3:0]  mux_sel;
   logic        mux_valid, sample_en, sar_start, sar_ready;
   logic [9:0]  sar_result, cur_val;
   logic [3:0]  cur_addr;
   logic        cur_slow;
   logic [15:0] got;
   int          failures, compares, cycles, starts, s0;
   sadc_row_t   rows [9];

   sadc_ctrl sadc_ctrl_inst (.ref_clk(ref_clk), .rst(rst), .serial_shift_clock(sck),
      .device_select_n(sel_n), .channel_address_in(adr), .result_serial_out(dout),
      .result_serial_oe(doe), .conversion_done(done), .mux_sel(mux_sel),
      .mux_valid(mux_valid), .sample_en(sample_en), .sar_start(sar_start),
      .sar_result(sar_result), .sar_ready(sar_ready));
   sadc_host sadc_host_inst (.lnk_clk(lnk_clk), .serial_shift_clock(sck),
      .device_select_n(sel_n), .channel_address_in(adr), .result_serial_out(dout),
      .result_serial_oe(doe));

   ////////////////////////////////////////////////////////////////////////////////
   // system clock 20 ns, link source 12 ns at an unrelated phase
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   initial begin
      lnk_clk = 1'b0;
      #3.7;
      forever #6 lnk_clk = ~lnk_clk;
   end

   // converter array: fast rows outlast the transfer, slow rows end after rising edge 11
   initial begin
      sar_ready  = 1'b0;
      sar_result = '0;
      starts     = 0;
      forever begin
         @(posedge ref_clk);
         #1;
         if (sar_start === 1'b1) begin
            starts++;
            repeat (cur_slow ? 30 : 150) @(posedge ref_clk);
            #1;
            sar_result = cur_val;
            sar_ready  = 1'b1;
            @(posedge ref_clk);
            #1;
            sar_ready  = 1'b0;
         end
      end
   end

   // in-frame checks on the rising shift edges
   always @(posedge sck) begin
      if (sel_n === 1'b0) begin
         #1;
         if (sadc_host_inst.rise_cnt == 3) `CHK(sample_en, 1'b0, "sampling early")
         if (sadc_host_inst.rise_cnt == 6) `CHK(sample_en, 1'b1, "not sampling")
         if (sadc_host_inst.rise_cnt == 6) `CHK(mux_sel, cur_addr, "address")
         if (sadc_host_inst.rise_cnt == 11) `CHK(sample_en, 1'b0, "not held")
      end
   end

   // hang guard: a run of eleven frames needs a few thousand cycles
   initial begin
      cycles = 0;
      forever begin
         @(posedge ref_clk);
         cycles++;
         if (cycles >= 30000) begin
            failures++;
            wrap_up();
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // bounded wait for the result, then let the output settle
   task automatic wait_done();
      int k;
      for (k = 0; k < 2000 && done !== 1'b1; k++) @(posedge ref_clk);
      if (k == 2000) `CHK(done, 1'b1, "no end of conversion")
      repeat (10) @(posedge ref_clk);
      #1;
   endtask

   initial begin
      failures = 0;
      compares = 0;
      rst      = 1'b1;
      cur_val  = '0;
      cur_addr = '0;
      cur_slow = 1'b0;
      // modes 1, 3, 3, 5, 1 (unknown code), 2, 4, 6, 6
      rows = '{'{4'h0, 10, 0, 0, 10'h2a5}, '{4'h5, 11, 0, 0, 10'h15a},
               '{4'ha, 16, 0, 0, 10'h3ff}, '{4'hb, 12, 0, 1, 10'h200},
               '{4'he, 10, 0, 0, 10'h001}, '{4'hc, 10, 1, 0, 10'h000},
               '{4'hd, 16, 1, 0, 10'h301}, '{4'hf, 16, 1, 1, 10'h0f0},
               '{4'h7, 16, 1, 1, 10'h155}};
      // link counters reset through their own sync, so clock the link in reset
      sadc_host_inst.idle_clocks(3);
      @(posedge ref_clk);
      #1;
      rst = 1'b0;
      `CHK(doe, 1'b0, "oe after reset")
      `CHK({done, mux_sel, mux_valid, sample_en}, 7'h40, "reset state")
      // link reset sync lets go two shift clocks after rst, so clock it idle first
      sadc_host_inst.idle_clocks(3);
      $display("reset test done");
      foreach (rows[i]) begin
         cur_val  = rows[i].val;
         cur_slow = rows[i].slow;
         cur_addr = rows[i].addr;
         sadc_host_inst.hp = rows[i].slow ? 20 : 10;
         sadc_host_inst.xfer(rows[i].addr, rows[i].n, rows[i].keep, got);
         if (i > 0) `CHK(got, {rows[i-1].val, 6'h00} >> (16 - rows[i].n), "data")
         if (!rows[i].slow) begin
            repeat (4) @(posedge ref_clk);
            #1;
            `CHK(done, 1'b0, "done not low")
         end
         if (!rows[i].keep) begin
            repeat (6) @(posedge ref_clk);
            #1;
            `CHK(doe, 1'b0, "oe after select rise")
         end
         wait_done();
         `CHK(mux_sel, rows[i].addr, "mux code")
         `CHK(mux_valid, rows[i].addr <= MAX_CHAN, "mux valid")
         $display("row %0d done", i);
      end
      sadc_host_inst.release_sel();
      // clocks and address with select high change nothing
      s0 = starts;
      sadc_host_inst.idle_clocks(6);
      `CHK(mux_sel, 4'h7, "address taken while idle")
      `CHK(doe, 1'b0, "oe while idle")
      `CHK(starts, s0, "start while idle")
      $display("idle test done");
      // nine clocks start nothing; the next frame restarts its counts
      sadc_host_inst.hp = 10;
      cur_val = 10'h0aa;
      cur_addr = 4'h3;
      sadc_host_inst.xfer(4'h3, 9, 1'b0, got);
      repeat (20) @(posedge ref_clk);
      #1;
      `CHK(got, {7'h00, rows[8].val[9:1]}, "short frame data")
      `CHK(starts, s0, "short frame converted")
      `CHK(done, 1'b1, "short frame done")
      cur_addr = 4'h9;
      sadc_host_inst.xfer(4'h9, 10, 1'b0, got);
      `CHK(got, {6'h00, rows[8].val}, "frame after abort")
      wait_done();
      `CHK(starts, s0 + 1, "one start")
      `CHK(mux_sel, 4'h9, "mux after abort")
      $display("abort test done");
      // reset in mid-run
      rst = 1'b1;
      sadc_host_inst.idle_clocks(3);
      @(posedge ref_clk);
      #1;
      rst = 1'b0;
      `CHK({doe, done, mux_sel, mux_valid}, 7'h20, "second reset")
      $display("second reset test done");
      wrap_up();
   end
endmodule
